// File: rtl/timer_pair_pkg.sv
// constants for the cascadable timer pair control block
// How it works
// - run_control starts counting when set, stops when clear; pair or single timer.
// - idle_halt_select set suspends counting while device is idle; clear keeps counting.
// - internal clock: gated_accumulate_enable set counts only while the gate input is high.
// - external clock selected: gated_accumulate_enable is ignored completely.
// - prescale_select 11=1:256, 10=1:64, 01=1:8, 00=1:1 on the timer input clock.
// - clock_source_select 1 counts external pin rising edges, 0 the peripheral clock.
// - control bits 14, 12..7, 2 and 0 always read as zero.
package timer_pair_pkg;
  localparam logic [11:0] ctrl_offset = 12'h000;
  localparam logic [11:0] low_count_offset = 12'h004;
  localparam logic [11:0] high_count_offset = 12'h008;
  localparam logic [11:0] period_low_offset = 12'h00C;
  localparam logic [11:0] period_high_offset = 12'h010;
  localparam int run_bit = 15;
  localparam int idle_bit = 13;
  localparam int gate_bit = 6;
  localparam int ps_hi_bit = 5;
  localparam int ps_lo_bit = 4;
  localparam int cascade_bit = 3;
  localparam int source_bit = 1;
  localparam logic [15:0] ctrl_write_mask = 16'hA07A;
  localparam logic [15:0] ctrl_reset = 16'h0000;
  localparam logic [15:0] period_reset = 16'hFFFF;
  localparam logic [7:0] div_1 = 8'h00;
  localparam logic [7:0] div_8 = 8'h07;
  localparam logic [7:0] div_64 = 8'h3F;
  localparam logic [7:0] div_256 = 8'hFF;
  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic [2:0] hsize_word = 3'h2;
endpackage

// File: rtl/timer_pair_control.sv
// cascadable 16/32-bit timer with prescaler, gating and ahb-lite registers
`timescale 1ns/1ps
`default_nettype none
module timer_pair_control
  import timer_pair_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // register bus, ahb-lite slave side
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // device state, count and gate pins
  input wire logic device_idle,
  input wire logic external_count_input,
  input wire logic gate_input,
  output logic period_match
);
  ////////////////////////////////////////////////////////////////////
  // bus address phase capture
  // the slave never stalls: every transfer is one address cycle
  // followed by one data cycle, so only a pending-write flag and the
  // word address of that write need to be kept across the edge

  // write pending flag and latched word address
  logic wr_pend_q;
  logic [11:0] addr_q;

  // software visible state
  logic [15:0] ctrl_q;
  logic [15:0] cnt_lo_q;
  logic [15:0] cnt_hi_q;
  logic [15:0] per_lo_q;
  logic [15:0] per_hi_q;

  // count path state
  logic [7:0] pre_q;
  logic ext_prev_q;
  logic match_q;

  // registered read data
  logic [31:0] rdata_q;

  // transfer accepted: selected, bus ready, single nonseq transfer
  wire logic take = hsel && hready && (htrans == htrans_nonseq);
  // byte lanes are ignored, every register is one aligned word
  wire logic [11:0] word_addr = {haddr[11:2], 2'h0};

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend_q <= 1'b0;
      addr_q <= 12'h000;
    end else begin
      wr_pend_q <= take && hwrite && (hsize == hsize_word);
      if (take) begin
        addr_q <= word_addr;
      end
    end
  end

  // write strobes in the data phase
  // hwdata only stands one cycle after the address, hence the pending flag
  wire logic wr_ctrl = wr_pend_q && (addr_q == ctrl_offset);
  wire logic wr_clo = wr_pend_q && (addr_q == low_count_offset);
  wire logic wr_chi = wr_pend_q && (addr_q == high_count_offset);
  wire logic wr_plo = wr_pend_q && (addr_q == period_low_offset);
  wire logic wr_phi = wr_pend_q && (addr_q == period_high_offset);

  ////////////////////////////////////////////////////////////////////
  // control field decode
  wire logic run = ctrl_q[run_bit];
  wire logic idle_halt = ctrl_q[idle_bit];
  wire logic gate_en = ctrl_q[gate_bit];
  wire logic [1:0] ps_sel = {ctrl_q[ps_hi_bit], ctrl_q[ps_lo_bit]};
  wire logic cascade = ctrl_q[cascade_bit];
  wire logic ext_src = ctrl_q[source_bit];

  ////////////////////////////////////////////////////////////////////
  // input clock selection and gating
  // the pin is taken as synchronous; one flop gives its rising edge,
  // and the flop resets to the pin's idle low level so no false edge
  wire logic ext_edge = external_count_input && !ext_prev_q;
  // the gate only applies to the internal clock
  wire logic gate_ok = ext_src || !gate_en || gate_input;
  wire logic tick_in = ext_src ? ext_edge : 1'b1;
  // run enable, suspended in idle only when asked to
  wire logic active = run && !(idle_halt && device_idle);

  // prescaler terminal count per divide setting
  wire logic [7:0] div_top = (ps_sel == 2'h3) ? div_256 :
                             (ps_sel == 2'h2) ? div_64 :
                             (ps_sel == 2'h1) ? div_8 : div_1;
  wire logic in_en = active && gate_ok && tick_in;
  // one counter step per full prescaler cycle
  wire logic pre_wrap = in_en && (pre_q >= div_top);

  // period compare, 32 bits when cascaded, else low half only
  wire logic [31:0] cnt_full = {cnt_hi_q, cnt_lo_q};
  wire logic [31:0] per_full = {per_hi_q, per_lo_q};
  wire logic hit32 = cascade && (cnt_full == per_full);
  wire logic hit16 = !cascade && (cnt_lo_q == per_lo_q);
  wire logic hit = hit32 || hit16;
  // next count values, wrapping to zero on a period hit
  wire logic [31:0] cnt_next = hit32 ? 32'h0000_0000 : cnt_full + 32'h0000_0001;
  wire logic [15:0] lo_next = hit16 ? 16'h0000 : cnt_lo_q + 16'h0001;

  ////////////////////////////////////////////////////////////////////
  // control register, unimplemented bits held at zero
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= ctrl_reset;
    end else if (wr_ctrl) begin
      ctrl_q <= hwdata[15:0] & ctrl_write_mask;
    end
  end

  // edge detector on the count pin
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ext_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= external_count_input;
    end
  end

  // prescaler, cleared on any control write so a new divide starts clean
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pre_q <= 8'h00;
    end else begin
      if (wr_ctrl || !run) begin
        pre_q <= 8'h00;
      end else if (pre_wrap) begin
        pre_q <= 8'h00;
      end else if (in_en) begin
        pre_q <= pre_q + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // period match pulse, one cycle per wrap
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      match_q <= 1'b0;
    end else begin
      match_q <= pre_wrap && hit;
    end
  end

  // low count: a bus write wins over a count step in the same cycle
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_lo_q <= 16'h0000;
    end else begin
      if (wr_clo) begin
        cnt_lo_q <= hwdata[15:0];
      end else if (pre_wrap && cascade) begin
        cnt_lo_q <= cnt_next[15:0];
      end else if (pre_wrap) begin
        cnt_lo_q <= lo_next;
      end
    end
  end

  // high count: counts only when cascaded; in 16-bit mode only a bus write changes it
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_hi_q <= 16'h0000;
    end else begin
      if (wr_chi) begin
        cnt_hi_q <= hwdata[15:0];
      end else if (pre_wrap && cascade) begin
        cnt_hi_q <= cnt_next[31:16];
      end
    end
  end

  // period registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      per_lo_q <= period_reset;
      per_hi_q <= period_reset;
    end else begin
      if (wr_plo) begin
        per_lo_q <= hwdata[15:0];
      end
      if (wr_phi) begin
        per_hi_q <= hwdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read mux, unmapped reads zero
  // selected in the address phase, registered for the data phase
  wire logic [15:0] rd_sel = (word_addr == ctrl_offset) ? ctrl_q :
                             (word_addr == low_count_offset) ? cnt_lo_q :
                             (word_addr == high_count_offset) ? cnt_hi_q :
                             (word_addr == period_low_offset) ? per_lo_q :
                             (word_addr == period_high_offset) ? per_hi_q : 16'h0000;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      rdata_q <= {16'h0000, rd_sel};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs
  // read data from a flop, the bus answer is always ready and okay
  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // match pulse straight from its flop
  assign period_match = match_q;
endmodule
`default_nettype wire

// File: bench/timer_pair_control_asserts.sv
// bus answer and count enable checker for the timer pair block
`timescale 1ns/1ps
`default_nettype none
module timer_pair_control_asserts
  import timer_pair_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic device_idle,
  input wire logic external_count_input,
  input wire logic gate_input,
  input wire logic period_match
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // shadow of the control register, rebuilt from bus writes
  logic ctrl_wr_q;
  logic [15:0] ctrl_seen_q;
  wire logic taken = hsel && hready && (htrans == htrans_nonseq);
  wire logic ctrl_addr = (haddr[11:2] == ctrl_offset[11:2]);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_wr_q <= 1'b0;
      ctrl_seen_q <= ctrl_reset;
    end else begin
      ctrl_wr_q <= taken && hwrite && (hsize == hsize_word) && ctrl_addr;
      if (ctrl_wr_q) begin
        ctrl_seen_q <= hwdata[15:0];
      end
    end
  end
  property p_ready; hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("hreadyout low");
  property p_okay; !hresp; endproperty
  a_okay: assert property (p_okay) else $error("hresp not okay");
  property p_stopped; !ctrl_seen_q[run_bit] |=> !period_match; endproperty
  a_stopped: assert property (p_stopped) else $error("match while stopped");
  property p_idle_halt; (ctrl_seen_q[idle_bit] && device_idle) |=> !period_match; endproperty
  a_idle_halt: assert property (p_idle_halt) else $error("match in halted idle");
  property p_gate_closed;
    (!ctrl_seen_q[source_bit] && ctrl_seen_q[gate_bit] && !gate_input) |=> !period_match;
  endproperty
  a_gate_closed: assert property (p_gate_closed) else $error("match with gate low");
  property p_no_edge;
    (ctrl_seen_q[source_bit] && !(external_count_input && !$past(external_count_input)))
      |=> !period_match;
  endproperty
  a_no_edge: assert property (p_no_edge) else $error("match without pin edge");
  property p_unimpl_zero;
    (taken && !hwrite && ctrl_addr) |=> ((hrdata[15:0] & ~ctrl_write_mask) == 16'h0000);
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unused ctrl bit set");
endmodule
////////////////////////////////
bind timer_pair_control timer_pair_control_asserts timer_pair_control_asserts_i (
  .clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .device_idle(device_idle),
  .external_count_input(external_count_input), .gate_input(gate_input),
  .period_match(period_match));
`default_nettype wire

// File: bench/timer_pair_control_bench.sv
// self-checking bench for the timer pair block
`timescale 1ns/1ps
`default_nettype none
module timer_pair_control_bench;
  import timer_pair_pkg::*;
  logic clock = 1'b0, reset_n = 1'b0, hwrite = 1'b0, device_idle = 1'b0, tg = 1'b0;
  logic external_count_input = 1'b0, gate_input = 1'b0, hready, hresp, period_match;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0] htrans = 2'h0;
  int err_count = 0, n_compared = 0, n;
  // clock, and a count pin toggling while tg is set
  always #20 clock = ~clock;
  always @(posedge clock) external_count_input <= tg & ~external_count_input;
  timer_pair_control timer_pair_control_i (.clock(clock), .reset_n(reset_n), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize_word), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .device_idle(device_idle), .external_count_input(external_count_input),
    .gate_input(gate_input), .period_match(period_match));
  task ck(input string nm, input logic [31:0] s, e);
    n_compared++;
    err_count += int'(s !== e);
    if (s !== e) $display("ERROR %s expected %h seen %h", nm, e, s);
  endtask
  task xf(input logic w, input logic [11:0] a, input logic [31:0] d);
    {hwrite, haddr, htrans} <= {w, 20'h0, a, htrans_nonseq};
    do @(posedge clock); while (hready !== 1'b1);
    {htrans, hwdata} <= {2'h0, d};
    do @(posedge clock); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task stop_test;
    if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // f holds gate, idle, pin toggling, count expected to move
  task held(input logic [15:0] c, input logic [3:0] f);
    {gate_input, device_idle, tg} <= f[3:1];
    xf(1'b1, ctrl_offset, {16'h0, c});
    xf(1'b1, low_count_offset, 32'h0);
    repeat (20) @(posedge clock);
    xf(1'b0, low_count_offset, 32'h0);
    ck("moved", {31'h0, r != 32'h0}, {31'h0, f[0]});
  endtask
  // cascaded pair must wrap the high half to zero at the 32-bit period
  task t_cascade;
    xf(1'b1, ctrl_offset, 32'h0);
    xf(1'b1, period_high_offset, 32'h1);
    xf(1'b1, period_low_offset, 32'h2);
    xf(1'b1, high_count_offset, 32'h1);
    xf(1'b1, low_count_offset, 32'h0);
    xf(1'b1, ctrl_offset, 32'h8008);
    do @(posedge clock); while (period_match !== 1'b1);
    xf(1'b1, ctrl_offset, 32'h0);
    xf(1'b0, high_count_offset, 32'h0);
    ck("cascade_high", r, 32'h0);
  endtask
  task t_prescale;
    xf(1'b1, period_low_offset, 32'h1);
    for (int p = 0; p < 4; p++) begin
      xf(1'b1, low_count_offset, 32'h0);
      xf(1'b1, ctrl_offset, 32'h8000 | 32'(p << 4));
      do @(posedge clock); while (period_match !== 1'b1);
      n = 0;
      do @(posedge clock); while (++n > 0 && period_match !== 1'b1);
      ck("gap", 32'(n), p == 3 ? 32'h200 : 32'(2 << 3 * p));
    end
  endtask
  initial begin
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    xf(1'b1, ctrl_offset, 32'hFFFF);
    xf(1'b0, ctrl_offset, 32'h0);
    ck("ctrl", r, 32'h0000A07A);
    held(16'h0000, 4'h0);
    held(16'h8000, 4'h5);
    held(16'hA000, 4'h4);
    held(16'h8040, 4'h0);
    held(16'h8040, 4'h9);
    held(16'h8042, 4'h3);
    t_prescale;
    t_cascade;
    stop_test;
  end
  initial begin
    #400000;
    err_count++;
    stop_test;
  end
endmodule
`default_nettype wire
